// >>> rtl/afc_pkg.sv
// package: timing counts and constants for the fifo host controller
package afc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	// strobe low pulse width, least time
	localparam int unsigned STROBE_LOW_NS = 80;
	localparam int unsigned STROBE_LOW_CYC =
		(STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// strobe recovery (high) time, least time
	localparam int unsigned STROBE_HIGH_NS = 80;
	localparam int unsigned STROBE_HIGH_CYC =
		(STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// retransmit pulse width and recovery
	localparam int unsigned REWIND_LOW_NS = 80;
	localparam int unsigned REWIND_LOW_CYC =
		(REWIND_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned REWIND_REC_NS = 100;
	localparam int unsigned REWIND_REC_CYC =
		(REWIND_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// reset pulse width on the device reset pin
	localparam int unsigned CLEAR_LOW_NS = 100;
	localparam int unsigned CLEAR_LOW_CYC =
		(CLEAR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WORD_W = 9;
	localparam int unsigned CNT_W = 4;
	typedef enum logic [2:0] {
		AFC_IDLE,
		AFC_CLEAR,
		AFC_WR_LOW,
		AFC_RD_LOW,
		AFC_RW_LOW,
		AFC_REWIND,
		AFC_RECOVER
	} afc_state_e;
endpackage

// >>> rtl/afc_host.sv
// host controller that drives the strobe pins of one async fifo device
//
// How it works
// [RULE_01] pulse clear to zero both pointers
// [RULE_02] push only while no_room_n high
// [RULE_03] pop only while nothing_left_n high
// [RULE_04] first-load pin doubles as rewind request
// [RULE_05] chain_in_n low means single mode
// [RULE_06] rewind pulse resets read pointer only
// [RULE_07] both strobes high throughout rewind
// [RULE_08] no rewind in cascade; half re-evaluated
// [RULE_09] full flag blocks further writes
// [RULE_10] full after depth writes without reads
// [RULE_11] empty flag blocks further reads
// [RULE_12] half flag follows occupancy above half
// [RULE_13] single mode: chain_out_half_n is half
// [RULE_14] cascade: chain out pulses at last
// [RULE_15] chain out wired to next chain in
// [RULE_16] out_word driven only while popping
// [RULE_17] first_in_chain_n low on one device
// [RULE_18] composite flags ored by outside logic
// [RULE_19] cascade: no rewind, no half flag
// [RULE_20] width cascade shares control strobes
// [RULE_21] flow-through read waits for data
// [RULE_22] flow-through write stores on rise
// [RULE_23] toggle push strobe to store more
// [RULE_24] reset gives empty low, full high
// [RULE_25] pointers move only on flag high
// [RULE_26] half flag high after reset
// [RULE_27] pointers wrap as a ring
module afc_host #(
	parameter int unsigned DEPTH = 1024,
	parameter bit CASCADE = 1'b0,
	parameter bit FIRST_IN_CHAIN = 1'b1
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// user side
	input wire logic clear_req_in,
	input wire logic push_req_in,
	input wire logic [afc_pkg::WORD_W-1:0] push_word_in,
	input wire logic pop_req_in,
	input wire logic rewind_req_in,
	output logic push_ack_out,
	output logic pop_ack_out,
	output logic [afc_pkg::WORD_W-1:0] pop_word_out,
	output logic rewind_ack_out,
	output logic busy_out,
	output logic empty_out,
	output logic full_out,
	output logic half_out,
	// device pins
	output logic clear_n_out,
	output logic push_n_out,
	output logic pop_n_out,
	output logic first_load_retransmit_n_out,
	output logic chain_in_n_out,
	output logic [afc_pkg::WORD_W-1:0] in_word_out,
	input wire logic [afc_pkg::WORD_W-1:0] out_word_in,
	input wire logic no_room_n_in,
	input wire logic nothing_left_n_in,
	input wire logic chain_out_half_n_in
);
	// ==========================================================
	// state
	afc_pkg::afc_state_e state_ff, nxt_state;
	logic [afc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [afc_pkg::WORD_W-1:0] wdata_ff, nxt_wdata;
	logic [afc_pkg::WORD_W-1:0] rdata_ff, nxt_rdata;
	logic push_ack_ff, nxt_push_ack;
	logic pop_ack_ff, nxt_pop_ack;
	logic rew_ack_ff, nxt_rew_ack;
	logic push_ok, pop_ok, rewind_ok;

	localparam logic [afc_pkg::CNT_W-1:0] LOW_CNT = afc_pkg::CNT_W'(afc_pkg::STROBE_LOW_CYC);
	localparam logic [afc_pkg::CNT_W-1:0] HIGH_CNT = afc_pkg::CNT_W'(afc_pkg::STROBE_HIGH_CYC);
	localparam logic [afc_pkg::CNT_W-1:0] RW_CNT = afc_pkg::CNT_W'(afc_pkg::REWIND_LOW_CYC);
	localparam logic [afc_pkg::CNT_W-1:0] RWR_CNT = afc_pkg::CNT_W'(afc_pkg::REWIND_REC_CYC);
	localparam logic [afc_pkg::CNT_W-1:0] CLR_CNT = afc_pkg::CNT_W'(afc_pkg::CLEAR_LOW_CYC);

	// ==========================================================
	// pin and output assigns
	// [RULE_05] [RULE_15] chain in grounded; chain wiring external
	assign chain_in_n_out = 1'b0;
	// [RULE_17] only the first device of a chain holds first-load low
	assign first_load_retransmit_n_out =
		CASCADE ? !FIRST_IN_CHAIN : !(state_ff == afc_pkg::AFC_REWIND);
	assign clear_n_out = !(state_ff == afc_pkg::AFC_CLEAR);
	assign push_n_out = !(state_ff == afc_pkg::AFC_WR_LOW || state_ff == afc_pkg::AFC_RW_LOW);
	assign pop_n_out = !(state_ff == afc_pkg::AFC_RD_LOW || state_ff == afc_pkg::AFC_RW_LOW);
	assign in_word_out = wdata_ff;
	assign pop_word_out = rdata_ff;
	assign push_ack_out = push_ack_ff;
	assign pop_ack_out = pop_ack_ff;
	assign rewind_ack_out = rew_ack_ff;
	assign busy_out = state_ff != afc_pkg::AFC_IDLE;
	// [RULE_18] [RULE_20] flags of one device
	assign empty_out = !nothing_left_n_in;
	assign full_out = !no_room_n_in;
	// [RULE_19] half flag meaningless in cascade mode
	assign half_out = !CASCADE && !chain_out_half_n_in;

	// ==========================================================
	// strobe sequencer
	// [RULE_02] start a push only while the device has room
	assign push_ok = push_req_in && no_room_n_in;
	// [RULE_03] start a pop only while the device holds data
	assign pop_ok = pop_req_in && nothing_left_n_in;
	// [RULE_08] rewind only in single mode
	assign rewind_ok = rewind_req_in && !CASCADE;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_push_ack = 1'b0;
		nxt_pop_ack = 1'b0;
		nxt_rew_ack = 1'b0;
		case (state_ff)
			afc_pkg::AFC_IDLE: begin
				// [RULE_01] clear has priority over every other request
				if (clear_req_in) begin
					nxt_state = afc_pkg::AFC_CLEAR;
					nxt_cnt = CLR_CNT;
				end else if (rewind_ok) begin
					// [RULE_07] both strobes stay high for the rewind pulse
					nxt_state = afc_pkg::AFC_REWIND;
					nxt_cnt = RW_CNT;
				end else if (push_ok && pop_ok) begin
					nxt_state = afc_pkg::AFC_RW_LOW;
					nxt_cnt = LOW_CNT;
					nxt_wdata = push_word_in;
				end else if (push_ok) begin
					nxt_state = afc_pkg::AFC_WR_LOW;
					nxt_cnt = LOW_CNT;
					nxt_wdata = push_word_in;
				end else if (pop_ok) begin
					nxt_state = afc_pkg::AFC_RD_LOW;
					nxt_cnt = LOW_CNT;
				end
			end
			afc_pkg::AFC_CLEAR: begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == 1) begin
					nxt_state = afc_pkg::AFC_RECOVER;
					nxt_cnt = RWR_CNT;
				end
			end
			afc_pkg::AFC_WR_LOW, afc_pkg::AFC_RD_LOW, afc_pkg::AFC_RW_LOW: begin
				nxt_cnt = cnt_ff - 1'b1;
				// [RULE_16] capture while the device drives out_word
				if (cnt_ff == 1) begin
					// [RULE_23] raising push stores the word; next push toggles again
					nxt_push_ack = state_ff != afc_pkg::AFC_RD_LOW;
					nxt_pop_ack = state_ff != afc_pkg::AFC_WR_LOW;
					if (state_ff != afc_pkg::AFC_WR_LOW) begin
						nxt_rdata = out_word_in;
					end
					nxt_state = afc_pkg::AFC_RECOVER;
					nxt_cnt = HIGH_CNT;
				end
			end
			afc_pkg::AFC_REWIND: begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == 1) begin
					nxt_rew_ack = 1'b1;
					nxt_state = afc_pkg::AFC_RECOVER;
					nxt_cnt = RWR_CNT;
				end
			end
			afc_pkg::AFC_RECOVER: begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_ff == 1) begin
					nxt_state = afc_pkg::AFC_IDLE;
				end
			end
			default: begin
				nxt_state = afc_pkg::AFC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= afc_pkg::AFC_IDLE;
			cnt_ff <= '0;
			wdata_ff <= '0;
			rdata_ff <= '0;
			push_ack_ff <= 1'b0;
			pop_ack_ff <= 1'b0;
			rew_ack_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			push_ack_ff <= nxt_push_ack;
			pop_ack_ff <= nxt_pop_ack;
			rew_ack_ff <= nxt_rew_ack;
		end
	end

	// ==========================================================
	// checks
	rewind_strobes_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_07
		!first_load_retransmit_n_out && !CASCADE |-> push_n_out && pop_n_out)
		else $error("strobe low during rewind");
	push_gate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_02
		$fell(push_n_out) |-> $past(no_room_n_in))
		else $error("push started while device full");
	pop_gate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_03
		$fell(pop_n_out) |-> $past(nothing_left_n_in))
		else $error("pop started while device empty");
	clear_excl_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_01
		!clear_n_out |-> push_n_out && pop_n_out)
		else $error("strobe low during clear");
	push_pulse_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_23
		$fell(push_n_out) |-> !push_n_out [*1] ##1 push_n_out [*1] ##0 push_ack_out)
		else $error("push pulse width or ack wrong");
	pop_data_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_16
		$fell(pop_n_out) |-> ##1 pop_ack_out && pop_word_out == $past(out_word_in))
		else $error("pop word not captured at strobe rise");
	cascade_rew_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_19
		CASCADE |-> first_load_retransmit_n_out == !FIRST_IN_CHAIN && !half_out)
		else $error("rewind or half used in cascade");
	rewind_ack_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_06
		$rose(first_load_retransmit_n_out) && !CASCADE |-> rewind_ack_out)
		else $error("rewind ack missing");
endmodule

// >>> verification/afc_dev_model.sv
// behavioural model of one small async fifo device, single mode; in cascade mode only the half flag and rewind are disabled
module afc_dev_model #(
	parameter int DEPTH = 8
) (
	input wire logic clear_n_in,
	input wire logic push_n_in,
	input wire logic pop_n_in,
	input wire logic rewind_n_in,
	input wire logic chain_in_n_in,
	input wire logic [8:0] in_word_in,
	output logic [8:0] out_word_out,
	output logic no_room_n_out,
	output logic nothing_left_n_out,
	output logic chain_out_half_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] mem [DEPTH];
	int wr_i;
	int rd_i;
	bit ok_w;
	bit ok_r;
	assign nothing_left_n_out = (wr_i != rd_i);
	assign no_room_n_out = (wr_i - rd_i != DEPTH);
	// half flag in single mode only
	// cascade chain pulse is not modelled: the host runs one device alone
	assign chain_out_half_n_out = chain_in_n_in | (wr_i - rd_i <= DEPTH / 2);
	initial out_word_out = 9'h155;
	always @(negedge clear_n_in) begin
		wr_i = 0;
		rd_i = 0;
	end
	// write accepted only with room at the falling edge
	always @(negedge push_n_in) ok_w = no_room_n_out;
	// word stored on the rise, index wraps as a ring
	// data is taken at the rise: it may still be settling at the falling edge
	always @(posedge push_n_in) if (ok_w) begin
		mem[wr_i % DEPTH] = in_word_in;
		wr_i++;
	end
	// read data valid only while a read is low
	// flow-through read not modelled: the host never pops while empty
	always @(negedge pop_n_in) begin
		ok_r = nothing_left_n_out;
		if (ok_r) out_word_out = mem[rd_i % DEPTH];
	end
	// released bus flips so a late capture is caught
	always @(posedge pop_n_in) begin
		if (ok_r) rd_i++;
		out_word_out = ~out_word_out;
	end
	// rewind moves the read pointer only, single mode
	// read index goes back to ring location zero behind the write index
	always @(negedge rewind_n_in) if (!chain_in_n_in) rd_i = wr_i - ((wr_i - 1) % DEPTH + 1);
endmodule

// >>> verification/afc_host_tb_top.sv
// self-checking bench for the fifo host controller against a device model
module afc_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, clr = 0, psh = 0, pop = 0, rwd = 0;
	logic [8:0] pw = 9'h000, pword, iw, ow;
	logic pa, qa, ra, busy, emp, ful, hlf, cn, wn, rn, fl, ci, nr, nl, ch;
	int mismatches = 0, num_checks = 0;
	always #50 clk = ~clk;
	afc_host #(.DEPTH(8)) i_afc_host (.core_clk_in(clk), .rst_n_in(rst_n), .clear_req_in(clr),
		.push_req_in(psh), .push_word_in(pw), .pop_req_in(pop), .rewind_req_in(rwd),
		.push_ack_out(pa), .pop_ack_out(qa), .pop_word_out(pword), .rewind_ack_out(ra),
		.busy_out(busy), .empty_out(emp), .full_out(ful), .half_out(hlf), .clear_n_out(cn),
		.push_n_out(wn), .pop_n_out(rn), .first_load_retransmit_n_out(fl),
		.chain_in_n_out(ci), .in_word_out(iw), .out_word_in(ow), .no_room_n_in(nr),
		.nothing_left_n_in(nl), .chain_out_half_n_in(ch));
	afc_dev_model #(.DEPTH(8)) i_afc_dev_model (.clear_n_in(cn), .push_n_in(wn),
		.pop_n_in(rn), .rewind_n_in(fl), .chain_in_n_in(ci), .in_word_in(iw),
		.out_word_out(ow), .no_room_n_out(nr), .nothing_left_n_out(nl),
		.chain_out_half_n_out(ch));
	// ======================================
	// checking and closing
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ======================================
	// one request: k 0 clear, 1 push, 2 pop, 3 rewind, 4 push and pop; ok says an ack is due, except for clear, which never acks
	task automatic op(input int k, input logic [8:0] w, input bit ok);
		logic [2:0] got;
		got = 3'h0;
		pw = w;
		{rwd, pop, psh, clr} = (k == 4) ? 4'h6 : 4'h1 << k;
		@(negedge clk);
		{rwd, pop, psh, clr} = 4'h0;
		for (int n = 0; n < 8; n++) begin
			@(negedge clk);
			got |= {ra, qa, pa};
			if (busy !== 1'b1 && n > 2) break;
		end
		if (busy !== 1'b0) begin
			mismatches++;
			wrap_up();
		end
		chk({6'h00, got}, (!ok || k == 0) ? 9'h000 : (k == 4) ? 9'h003 : 9'h001 << (k - 1));
	endtask
	function automatic logic [8:0] pat(input int i);
		return 9'h150 + 9'(i * 37);
	endfunction
	// ======================================
	// main sequence
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1;
		op(0, 9'h000, 1);
		chk({6'h00, emp, ful, hlf}, 9'h004);
		op(2, 9'h000, 0);
		for (int i = 0; i < 8; i++) begin
			op(1, pat(i), 1);
			chk({7'h00, ful, hlf}, {7'h00, i == 7, i >= 4});
		end
		op(1, pat(9), 0);
		for (int i = 0; i < 3; i++) begin
			op(2, 9'h000, 1);
			chk(pword, pat(i));
		end
		chk({7'h00, ful, hlf}, 9'h001);
		op(3, 9'h000, 1);
		chk({6'h00, emp, ful, hlf}, 9'h003);
		for (int i = 0; i < 8; i++) begin
			op(2, 9'h000, 1);
			chk(pword, pat(i));
		end
		chk({7'h00, emp, hlf}, 9'h002);
		op(2, 9'h000, 0);
		for (int i = 0; i < 3; i++) op(1, pat(i + 8), 1);
		for (int i = 0; i < 3; i++) begin
			op(2, 9'h000, 1);
			chk(pword, pat(i + 8));
		end
		op(1, pat(20), 1);
		op(4, pat(21), 1);
		chk(pword, pat(20));
		op(2, 9'h000, 1);
		chk(pword, pat(21));
		op(0, 9'h000, 1);
		chk({7'h00, emp, ful}, 9'h002);
		wrap_up();
	end
endmodule
